// file: src/nibble_alu_pkg.sv
// Shared constants and types of the nibble arithmetic unit.
package nibble_alu_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Bus geometry and answers.
	localparam int         ADDR_W      = 8;
	localparam int         DATA_W      = 32;
	localparam int         STRB_W      = 4;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////////
	// Register byte offsets.
	localparam logic [7:0] OFS_PSW      = 8'h00;
	localparam logic [7:0] OFS_OPCODE   = 8'h04;
	localparam logic [7:0] OFS_OFFSET   = 8'h08;
	localparam logic [7:0] OFS_TABLE    = 8'h0c;
	localparam logic [7:0] OFS_SELECT   = 8'h10;
	localparam logic [7:0] OFS_MEM_ADDR = 8'h14;
	localparam logic [7:0] OFS_MEM_DATA = 8'h18;
	localparam logic [7:0] OFS_STATUS   = 8'h1c;

	////////////////////////////////////////////////////////////////////////////
	// Program state word bits, select fields and status fields.
	localparam int PSW_CMP_BIT    = 0;
	localparam int PSW_DEC_BIT    = 1;
	localparam int PSW_IDX_BIT    = 2;
	localparam int PSW_CARRY_BIT  = 3;
	localparam int PSW_ZERO_BIT   = 4;
	localparam int SEL_BANK_LO    = 0;
	localparam int SEL_ROW_LO     = 4;
	localparam int STAT_ADDR_LO   = 0;
	localparam int STAT_RESULT_LO = 16;
	localparam int STAT_BAD_BIT   = 20;

	////////////////////////////////////////////////////////////////////////////
	// Opcode fields and codes.
	localparam int         OP_HI        = 15;
	localparam int         OP_LO        = 11;
	localparam int         ROW_HI       = 10;
	localparam int         ROW_LO       = 8;
	localparam int         COL_HI       = 7;
	localparam int         COL_LO       = 4;
	localparam int         LOW_HI       = 3;
	localparam int         LOW_LO       = 0;
	localparam logic [4:0] OP_ADD_REG   = 5'h00;
	localparam logic [4:0] OP_ADD_IMM   = 5'h10;
	localparam logic [4:0] OP_SUM_WITH_CARRY_OP_REG  = 5'h02;
	localparam logic [4:0] OP_SUM_WITH_CARRY_OP_IMM  = 5'h12;
	localparam logic [4:0] OP_SYSTEM    = 5'h07;
	localparam logic [2:0] SYS_ROW_INC  = 3'h0;
	localparam logic [3:0] SYS_COL_IX   = 4'h8;
	localparam logic [3:0] SYS_COL_TBL  = 4'h9;
	localparam logic [3:0] SYS_LOW_INC  = 4'h0;

	////////////////////////////////////////////////////////////////////////////
	// Reset values, masks and storage size.
	localparam logic [4:0]  PSW_RESET    = 5'h00;
	localparam logic [15:0] OPCODE_RESET = 16'h0000;
	localparam logic [11:0] OFFSET_RESET = 12'h000;
	localparam logic [15:0] TABLE_RESET  = 16'h0000;
	localparam logic [15:0] TABLE_MASK   = 16'h03ff;
	localparam int          DM_WORDS     = 128;
	localparam int          DM_IDX_W     = 7;
	localparam int          DM_ADDR_W    = 11;
	localparam logic [3:0]  DEC_LIMIT    = 4'h9;
	localparam logic [3:0]  DEC_ADJUST   = 4'h6;

	typedef logic [3:0] nibble_t;

endpackage : nibble_alu_pkg

// file: src/nibble_adder.sv
// Four-bit adder with optional decimal correction.
`timescale 1ns/1ps
module nibble_adder (
	// Operands.
	input  nibble_alu_pkg::nibble_t augend,
	input  nibble_alu_pkg::nibble_t addend,
	input  logic                    carry_in,
	// Mode.
	input  logic                    decimal_mode,
	// Result.
	output nibble_alu_pkg::nibble_t sum,
	output logic                    carry_out
);
	import nibble_alu_pkg::*;

	logic [4:0] raw;

	// Binary sum first; a decimal sum above nine is pushed past fifteen by six.
	always_comb begin
		raw = {1'b0, augend} + {1'b0, addend} + {4'h0, carry_in};
		if (decimal_mode && (raw > {1'b0, DEC_LIMIT})) begin
			sum       = raw[3:0] + DEC_ADJUST;
			carry_out = 1'b1;
		end else begin
			sum       = raw[3:0];
			carry_out = raw[4];
		end
	end

endmodule : nibble_adder

// file: src/nibble_add_carry_increment_unit.sv
// Nibble add-with-carry and pointer increment unit behind an AXI4-Lite slave.
// Functional notes
// - Add-register-with-carry decodes from top bits 00010, row, column, register fields.
// - Compare flag clear: register gets register plus memory plus carry.
// - Compare flag set: destination kept, carry still updated, zero only cleared by a nonzero result.
// - Carry flag set on nibble overflow, or in decimal mode on a sum above nine, cleared otherwise.
// - Nonzero result always clears the zero flag.
// - Zero result sets zero flag only when compare flag is clear.
// - Decimal mode flag selects binary or decimal-corrected addition.
// - Immediate form writes memory plus immediate plus carry back to memory.
// - Index apply set: memory address is index ORed with bank and operand.
// - Index increment adds one across the 12-bit high, middle, low nibbles.
// - Index increment decodes from fields 00111, 000, 1000, 0000.
// - Table pointer increment adds one across its four nibbles.
// - Upper six table pointer bits always read zero.
`timescale 1ns/1ps
module nibble_add_carry_increment_unit (
	// Clock and reset.
	input  logic                                 aclk,
	input  logic                                 aresetn,
	// Write address channel.
	input  logic [nibble_alu_pkg::ADDR_W-1:0]    awaddr,
	input  logic                                 awvalid,
	output logic                                 awready,
	// Write data channel.
	input  logic [nibble_alu_pkg::DATA_W-1:0]    wdata,
	input  logic [nibble_alu_pkg::STRB_W-1:0]    wstrb,
	input  logic                                 wvalid,
	output logic                                 wready,
	// Write response channel.
	output logic [1:0]                           bresp,
	output logic                                 bvalid,
	input  logic                                 bready,
	// Read address channel.
	input  logic [nibble_alu_pkg::ADDR_W-1:0]    araddr,
	input  logic                                 arvalid,
	output logic                                 arready,
	// Read data channel.
	output logic [nibble_alu_pkg::DATA_W-1:0]    rdata,
	output logic [1:0]                           rresp,
	output logic                                 rvalid,
	input  logic                                 rready
);
	import nibble_alu_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// State of the whole unit.

	typedef struct packed {
		logic                          aw_held;
		logic [ADDR_W-1:0]             aw_addr;
		logic                          w_held;
		logic [DATA_W-1:0]             w_data;
		logic [STRB_W-1:0]             w_strb;
		logic                          bvalid;
		logic [1:0]                    bresp;
		logic                          rvalid;
		logic [DATA_W-1:0]             rdata;
		logic [1:0]                    rresp;
		logic [4:0]                    program_state_word;
		logic [15:0]                   opcode;
		logic [11:0]                   offset_pointer;
		logic [15:0]                   table_pointer;
		logic [3:0]                    bank;
		logic [2:0]                    gr_row;
		logic [DM_IDX_W-1:0]           mem_addr;
		logic [DM_ADDR_W-1:0]          last_address;
		logic [3:0]                    last_result;
		logic                          bad_opcode;
		logic [DM_WORDS-1:0][3:0]      mem;
	} unit_state_t;

	// Present state and the value that it takes at the next edge.
	unit_state_t st;
	unit_state_t next_st;

	////////////////////////////////////////////////////////////////////////////
	// Helper functions.

	// True for every byte address that holds a register.
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
		reg_hit = (a == OFS_PSW) || (a == OFS_OPCODE) || (a == OFS_OFFSET) ||
			(a == OFS_TABLE) || (a == OFS_SELECT) || (a == OFS_MEM_ADDR) ||
			(a == OFS_MEM_DATA) || (a == OFS_STATUS);
	endfunction : reg_hit

	// Current word of a register; unused bits and unmapped addresses give zero.
	function automatic logic [DATA_W-1:0] reg_read(input unit_state_t s,
		input logic [ADDR_W-1:0] a);
		reg_read = '0;
		case (a)
			OFS_PSW: begin
				reg_read[4:0] = s.program_state_word;
			end
			OFS_OPCODE: begin
				reg_read[15:0] = s.opcode;
			end
			OFS_OFFSET: begin
				reg_read[11:0] = s.offset_pointer;
			end
			OFS_TABLE: begin
				reg_read[15:0] = s.table_pointer & TABLE_MASK;
			end
			OFS_SELECT: begin
				reg_read[SEL_BANK_LO +: 4] = s.bank;
				reg_read[SEL_ROW_LO +: 3]  = s.gr_row;
			end
			OFS_MEM_ADDR: begin
				reg_read[DM_IDX_W-1:0] = s.mem_addr;
			end
			OFS_MEM_DATA: begin
				reg_read[3:0] = s.mem[s.mem_addr];
			end
			OFS_STATUS: begin
				reg_read[STAT_ADDR_LO +: DM_ADDR_W] = s.last_address;
				reg_read[STAT_RESULT_LO +: 4]       = s.last_result;
				reg_read[STAT_BAD_BIT]              = s.bad_opcode;
			end
			default: begin
				reg_read = '0;
			end
		endcase
	endfunction : reg_read

	// Only the low address bits select a nibble of the local array.
	function automatic logic [DM_IDX_W-1:0] dm_index(input logic [DM_ADDR_W-1:0] a);
		dm_index = a[DM_IDX_W-1:0];
	endfunction : dm_index

	////////////////////////////////////////////////////////////////////////////
	// Working signals of the datapath.

	logic                 commit;
	logic [DATA_W-1:0]    old_word;
	logic [DATA_W-1:0]    wr_value;
	logic [15:0]          exec_op;
	logic [4:0]           op_top;
	logic [2:0]           op_row;
	logic [3:0]           op_col;
	logic [3:0]           op_low;
	logic                 is_reg_form;
	logic                 is_imm_form;
	logic                 with_carry;
	logic                 is_inc_ix;
	logic                 is_inc_tbl;
	logic [DM_ADDR_W-1:0] base_address;
	logic [DM_ADDR_W-1:0] m_address;
	logic [DM_ADDR_W-1:0] gr_address;
	logic [DM_IDX_W-1:0]  m_index;
	logic [DM_IDX_W-1:0]  gr_index;
	nibble_t              add_a;
	nibble_t              add_b;
	logic                 add_cin;
	nibble_t              add_sum;
	logic                 add_cout;
	logic                 cmp_only;

	////////////////////////////////////////////////////////////////////////////
	// Opcode decode and operand selection.

	// A register write is carried out once both address and data are held.
	assign commit   = st.aw_held && st.w_held && !st.bvalid;
	assign old_word = reg_read(st, st.aw_addr);

	// Byte lanes not strobed keep the register's present contents.
	always_comb begin
		for (int i = 0; i < STRB_W; i++) begin
			wr_value[i*8 +: 8] = st.w_strb[i] ? st.w_data[i*8 +: 8] : old_word[i*8 +: 8];
		end
	end

	// The opcode is split into its fields as it is written, so it runs at once.
	assign exec_op = wr_value[15:0];
	assign op_top  = exec_op[OP_HI:OP_LO];
	assign op_row  = exec_op[ROW_HI:ROW_LO];
	assign op_col  = exec_op[COL_HI:COL_LO];
	assign op_low  = exec_op[LOW_HI:LOW_LO];

	// Register forms read the general register, immediate forms the operand field.
	assign is_reg_form = (op_top == OP_ADD_REG) || (op_top == OP_SUM_WITH_CARRY_OP_REG);
	assign is_imm_form = (op_top == OP_ADD_IMM) || (op_top == OP_SUM_WITH_CARRY_OP_IMM);
	assign with_carry  = (op_top == OP_SUM_WITH_CARRY_OP_REG) || (op_top == OP_SUM_WITH_CARRY_OP_IMM);

	// System forms are matched on all four fields so stray codes only raise the bad opcode status flag.
	assign is_inc_ix  = (op_top == OP_SYSTEM) && (op_row == SYS_ROW_INC) &&
		(op_col == SYS_COL_IX) && (op_low == SYS_LOW_INC);
	assign is_inc_tbl = (op_top == OP_SYSTEM) && (op_row == SYS_ROW_INC) &&
		(op_col == SYS_COL_TBL) && (op_low == SYS_LOW_INC);

	// Operand address, widened by the index only while index apply is set.
	assign base_address = {st.bank, op_row, op_col};
	assign m_address    = st.program_state_word[PSW_IDX_BIT] ?
		(base_address | st.offset_pointer[DM_ADDR_W-1:0]) :
		base_address;

	// The general register is never indexed.
	assign gr_address = {st.bank, st.gr_row, op_low};
	assign m_index    = dm_index(m_address);
	assign gr_index   = dm_index(gr_address);

	assign cmp_only = st.program_state_word[PSW_CMP_BIT];
	assign add_a    = is_reg_form ? st.mem[gr_index] : st.mem[m_index];
	assign add_b    = is_reg_form ? st.mem[m_index] : op_low;
	assign add_cin  = with_carry & st.program_state_word[PSW_CARRY_BIT];

	// Binary or decimal sum, chosen by the decimal mode flag.
	nibble_adder adder (
		.augend       (add_a),
		.addend       (add_b),
		.carry_in     (add_cin),
		.decimal_mode (st.program_state_word[PSW_DEC_BIT]),
		.sum          (add_sum),
		.carry_out    (add_cout)
	);

	////////////////////////////////////////////////////////////////////////////
	// Bus handshakes.

	// Each channel stays ready until its item is held; a pending answer blocks both.
	assign awready = !st.aw_held && !st.bvalid;
	assign wready  = !st.w_held && !st.bvalid;
	assign arready = !st.rvalid;
	assign bvalid  = st.bvalid;
	assign bresp   = st.bresp;
	assign rvalid  = st.rvalid;
	assign rdata   = st.rdata;
	assign rresp   = st.rresp;

	////////////////////////////////////////////////////////////////////////////
	// Next state.

	// Every update is worked out from the present state, so execution sees old values.
	always_comb begin
		next_st = st;

		// Capture write address and data in either order.
		if (awvalid && awready) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			next_st.w_held = 1'b1;
			next_st.w_data = wdata;
			next_st.w_strb = wstrb;
		end
		if (st.bvalid && bready) begin
			next_st.bvalid = 1'b0;
		end

		// Reads answer one cycle after the address is taken.
		if (arvalid && arready) begin
			next_st.rvalid = 1'b1;
			next_st.rdata  = reg_read(st, araddr);
			next_st.rresp  = reg_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		if (st.rvalid && rready) begin
			next_st.rvalid = 1'b0;
		end

		// Register write and, for the opcode register, execution.
		if (commit) begin
			next_st.aw_held = 1'b0;
			next_st.w_held  = 1'b0;
			next_st.bvalid  = 1'b1;
			next_st.bresp   = reg_hit(st.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			case (st.aw_addr)
				OFS_PSW: begin
					next_st.program_state_word = wr_value[4:0];
				end
				OFS_OPCODE: begin
					next_st.opcode     = exec_op;
					next_st.bad_opcode = 1'b0;
					if (is_reg_form || is_imm_form) begin
						next_st.program_state_word[PSW_CARRY_BIT] = add_cout;
						if (add_sum != 4'h0) begin
							next_st.program_state_word[PSW_ZERO_BIT] = 1'b0;
						end else if (!cmp_only) begin
							next_st.program_state_word[PSW_ZERO_BIT] = 1'b1;
						end
						// A compare leaves the destination untouched.
						if (!cmp_only) begin
							if (is_reg_form) begin
								next_st.mem[gr_index] = add_sum;
							end else begin
								next_st.mem[m_index] = add_sum;
							end
						end
						next_st.last_address = m_address;
						next_st.last_result  = add_sum;
					end else if (is_inc_ix) begin
						next_st.offset_pointer = st.offset_pointer + 12'h001;
					end else if (is_inc_tbl) begin
						// Full-width carry chain, then the upper bits forced low.
						next_st.table_pointer = (st.table_pointer + 16'h0001) &
							TABLE_MASK;
					end else begin
						next_st.bad_opcode = 1'b1;
					end
				end
				OFS_OFFSET: begin
					next_st.offset_pointer = wr_value[11:0];
				end
				OFS_TABLE: begin
					next_st.table_pointer = wr_value[15:0] & TABLE_MASK;
				end
				OFS_SELECT: begin
					next_st.bank   = wr_value[SEL_BANK_LO +: 4];
					next_st.gr_row = wr_value[SEL_ROW_LO +: 3];
				end
				OFS_MEM_ADDR: begin
					next_st.mem_addr = wr_value[DM_IDX_W-1:0];
				end
				OFS_MEM_DATA: begin
					next_st.mem[st.mem_addr] = wr_value[3:0];
				end
				default: begin
					// Status is read-only and unmapped words store nothing.
					next_st.bad_opcode = st.bad_opcode;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register.

	// Memory is cleared at reset as well, which costs area but keeps runs repeatable.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st                    <= '0;
			st.program_state_word <= PSW_RESET;
			st.opcode             <= OPCODE_RESET;
			st.offset_pointer     <= OFFSET_RESET;
			st.table_pointer      <= TABLE_RESET;
			st.bresp              <= RESP_OKAY;
			st.rresp              <= RESP_OKAY;
		end else begin
			st <= next_st;
		end
	end

endmodule : nibble_add_carry_increment_unit

// file: dv/nibble_alu_chk.sv
// Bus timing and read-back checks of the nibble arithmetic unit.
`timescale 1ns/1ps
module nibble_alu_chk (
	// Clock and reset.
	input logic					aclk,
	input logic					aresetn,
	// Write side.
	input logic [nibble_alu_pkg::ADDR_W-1:0]	awaddr,
	input logic					awvalid,
	input logic					awready,
	input logic [nibble_alu_pkg::DATA_W-1:0]	wdata,
	input logic [nibble_alu_pkg::STRB_W-1:0]	wstrb,
	input logic					wvalid,
	input logic					wready,
	input logic [1:0]				bresp,
	input logic					bvalid,
	input logic					bready,
	// Read side.
	input logic [nibble_alu_pkg::ADDR_W-1:0]	araddr,
	input logic					arvalid,
	input logic					arready,
	input logic [nibble_alu_pkg::DATA_W-1:0]	rdata,
	input logic [1:0]				rresp,
	input logic					rvalid,
	input logic					rready
);
	import nibble_alu_pkg::*;
	logic	aw_seen;
	logic	w_seen;
	logic	aw_now;
	logic	w_now;

	////////////////////////////////////////////////////////////////////////////
	// A half-taken write is remembered, since the answer is timed from the later half.
	assign aw_now = aw_seen || (awvalid && awready);
	assign w_now = w_seen || (wvalid && wready);

	// Halves are dropped once both are in, so the next write starts clean.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_seen <= 1'b0;
			w_seen <= 1'b0;
		end else begin
			aw_seen <= aw_now && !w_now;
			w_seen <= w_now && !aw_now;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Every check shares the bus clock and its reset.
	default clocking dcb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence both_taken;
		aw_now && w_now && !bvalid;
	endsequence
	sequence table_read;
		arvalid && arready && araddr == OFS_TABLE;
	endsequence
	sequence bad_read;
		arvalid && arready && (araddr > OFS_STATUS || araddr[1:0] != 2'h0);
	endsequence

	// The commit cycle sits between the later half and the answer.
	AST_WRITE_ANSWER: assert property (both_taken |=> !bvalid ##1 bvalid)
		else $error("write answer not two cycles after both halves");
	AST_WRITE_CAUSE: assert property ($rose(bvalid) |-> $past(aw_now && w_now, 2))
		else $error("write answer without a complete write");
	AST_BVALID_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped before it was taken");
	AST_AW_REFUSE: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while an answer is pending");
	AST_READ_ANSWER: assert property (arvalid && arready |=> rvalid)
		else $error("read answer not one cycle after the address");
	AST_RVALID_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer changed before it was taken");
	AST_READ_DONE: assert property (rvalid && rready |=> !rvalid && arready)
		else $error("read answer outlived its handshake");
	AST_BAD_READ: assert property (bad_read |=> rresp == RESP_SLVERR && rdata == '0)
		else $error("unmapped read not refused");
	AST_TABLE_TOP: assert property (table_read |=> rdata[31:10] == 22'h0)
		else $error("table pointer upper bits not zero");
endmodule : nibble_alu_chk

// file: dv/tb.sv
// Self-checking bench of the nibble arithmetic unit over its register bus.
`timescale 1ns/1ps
`define CHK(g, e, m) \
	begin \
		num_checks++; \
		if ((g) !== (e)) begin \
			fail_count++; \
			$display("wrong value at %0t: %s got %h expected %h", $time, m, g, e); \
		end \
	end
module tb;
	import nibble_alu_pkg::*;
	logic			aclk = 1'b0;
	logic			aresetn = 1'b0;
	logic [ADDR_W-1:0]	awaddr = '0;
	logic [ADDR_W-1:0]	araddr = '0;
	logic [DATA_W-1:0]	wdata = '0;
	logic [DATA_W-1:0]	rdata;
	logic [STRB_W-1:0]	wstrb = '0;
	logic [1:0]		bresp;
	logic [1:0]		rresp;
	logic			awvalid = 1'b0;
	logic			wvalid = 1'b0;
	logic			bready = 1'b0;
	logic			arvalid = 1'b0;
	logic			rready = 1'b0;
	logic			awready, wready, bvalid, arready, rvalid;
	int			fail_count = 0;
	int			num_checks = 0;
	int			slow = 0;

	// Bus clock of 20 ns.
	always #10 aclk = ~aclk;

	nibble_add_carry_increment_unit i_dut (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
	);

	////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (fail_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	// Handshakes are sampled mid-cycle, where ready has settled, and acted on at the edge.
	// With slow set the answer is left waiting two cycles before it is taken.
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s = 4'hf, input logic [1:0] er = RESP_OKAY);
		logic aw_t, w_t, b_t;
		int k;
		k = 0;
		b_t = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= (slow == 0);
		while (!b_t) begin
			@(negedge aclk);
			aw_t = awvalid && awready;
			w_t = wvalid && wready;
			b_t = bvalid && bready;
			if (bvalid && !bready) k++;
			if (b_t) `CHK(bresp, er, "write response")
			@(posedge aclk);
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
			if (k == 2 && !bready) bready <= 1'b1;
		end
	endtask : axi_write

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
			input logic [1:0] er = RESP_OKAY);
		logic ar_t, r_t;
		logic [31:0] d;
		logic [1:0] r;
		int k;
		k = 0;
		r_t = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= (slow == 0);
		while (!r_t) begin
			@(negedge aclk);
			ar_t = arvalid && arready;
			r_t = rvalid && rready;
			d = rdata;
			r = rresp;
			if (rvalid && !rready) k++;
			@(posedge aclk);
			if (ar_t) arvalid <= 1'b0;
			if (k == 2 && !rready) rready <= 1'b1;
		end
		`CHK(d, e, "read data")
		`CHK(r, er, "read response")
	endtask : rd_chk

	task automatic mem_set(input logic [7:0] i, input logic [3:0] v);
		axi_write(OFS_MEM_ADDR, {24'h0, i});
		axi_write(OFS_MEM_DATA, {28'h0, v});
	endtask : mem_set

	task automatic mem_chk(input logic [7:0] i, input logic [3:0] v);
		axi_write(OFS_MEM_ADDR, {24'h0, i});
		rd_chk(OFS_MEM_DATA, {28'h0, v});
	endtask : mem_chk

	// Operands sit at 0x03 (register) and 0x2f (memory); dst is where the result lands.
	task automatic add_case(input logic [4:0] p, input logic [3:0] r, input logic [3:0] m,
			input logic [15:0] op, input logic [7:0] dst, input logic [3:0] ed,
			input logic [4:0] ep, input logic [3:0] es);
		mem_set(8'h03, r);
		mem_set(8'h2f, m);
		axi_write(OFS_PSW, {27'h0, p});
		axi_write(OFS_OPCODE, {16'h0, op});
		mem_chk(dst, ed);
		rd_chk(OFS_PSW, {27'h0, ep});
		rd_chk(OFS_STATUS, {12'h0, es, 5'h0, 11'h02f});
	endtask : add_case

	////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset, bus answers, arithmetic, addressing, increments.
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_chk(OFS_PSW, 32'h0);
		rd_chk(OFS_TABLE, 32'h0);
		rd_chk(8'h20, 32'h0, RESP_SLVERR);
		rd_chk(8'h05, 32'h0, RESP_SLVERR);
		axi_write(8'h20, 32'h1, 4'hf, RESP_SLVERR);
		slow = 1;
		axi_write(OFS_OFFSET, 32'h123);
		axi_write(OFS_OFFSET, 32'hfff, 4'h1);
		rd_chk(OFS_OFFSET, 32'h1ff);
		slow = 0;
		add_case(5'h08, 4'h7, 4'h9, 16'h12f3, 8'h03, 4'h1, 5'h08, 4'h1);
		add_case(5'h11, 4'h8, 4'h8, 16'h12f3, 8'h03, 4'h8, 5'h19, 4'h0);
		add_case(5'h01, 4'h8, 4'h8, 16'h12f3, 8'h03, 4'h8, 5'h09, 4'h0);
		add_case(5'h11, 4'h1, 4'h1, 16'h12f3, 8'h03, 4'h1, 5'h01, 4'h2);
		add_case(5'h00, 4'h8, 4'h8, 16'h12f3, 8'h03, 4'h0, 5'h18, 4'h0);
		add_case(5'h18, 4'h2, 4'h3, 16'h12f3, 8'h03, 4'h6, 5'h00, 4'h6);
		add_case(5'h02, 4'h5, 4'h7, 16'h12f3, 8'h03, 4'h2, 5'h0a, 4'h2);
		add_case(5'h02, 4'h4, 4'h5, 16'h12f3, 8'h03, 4'h9, 5'h02, 4'h9);
		add_case(5'h0a, 4'h9, 4'h9, 16'h12f3, 8'h03, 4'h9, 5'h0a, 4'h9);
		add_case(5'h00, 4'h5, 4'h7, 16'h12f3, 8'h03, 4'hc, 5'h00, 4'hc);
		add_case(5'h08, 4'h7, 4'h9, 16'h02f3, 8'h03, 4'h0, 5'h18, 4'h0);
		add_case(5'h08, 4'h0, 4'he, 16'h92f1, 8'h2f, 4'h0, 5'h18, 4'h0);
		// The offset pointer redirects 0x2f to 0x6f only while index apply is set.
		mem_set(8'h6f, 4'h3);
		mem_set(8'h2f, 4'h1);
		axi_write(OFS_OFFSET, 32'h040);
		axi_write(OFS_PSW, 32'h04);
		axi_write(OFS_OPCODE, 32'h92f5);
		mem_chk(8'h6f, 4'h8);
		mem_chk(8'h2f, 4'h1);
		rd_chk(OFS_STATUS, 32'h0008_006f);
		axi_write(OFS_PSW, 32'h00);
		axi_write(OFS_OPCODE, 32'h92f5);
		mem_chk(8'h2f, 4'h6);
		mem_chk(8'h6f, 4'h8);
		axi_write(OFS_STATUS, 32'hffff_ffff);
		rd_chk(OFS_STATUS, 32'h0006_002f);
		// Increments carry across nibbles and leave the flags alone.
		axi_write(OFS_PSW, 32'h0a);
		axi_write(OFS_OFFSET, 32'h0ff);
		axi_write(OFS_OPCODE, 32'h3880);
		rd_chk(OFS_OFFSET, 32'h100);
		rd_chk(OFS_PSW, 32'h0a);
		axi_write(OFS_OFFSET, 32'hfff);
		axi_write(OFS_OPCODE, 32'h3880);
		rd_chk(OFS_OFFSET, 32'h000);
		axi_write(OFS_TABLE, 32'hffff);
		rd_chk(OFS_TABLE, 32'h3ff);
		axi_write(OFS_OPCODE, 32'h3890);
		rd_chk(OFS_TABLE, 32'h000);
		axi_write(OFS_TABLE, 32'h0ff);
		axi_write(OFS_OPCODE, 32'h3890);
		rd_chk(OFS_TABLE, 32'h100);
		// A stray system code only raises the status flag; a good opcode clears it.
		axi_write(OFS_OPCODE, 32'h3881);
		rd_chk(OFS_STATUS, 32'h0016_002f);
		rd_chk(OFS_OFFSET, 32'h000);
		rd_chk(OFS_PSW, 32'h0a);
		add_case(5'h08, 4'h5, 4'h3, 16'h82f4, 8'h2f, 4'h7, 5'h00, 4'h7);
		stop_test();
	end

	// The sequence needs about five hundred cycles; twenty thousand means a hang.
	initial begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		stop_test();
	end
endmodule : tb

bind nibble_add_carry_increment_unit nibble_alu_chk i_chk (
	.aclk(aclk), .aresetn(aresetn),
	.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
	.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
	.bresp(bresp), .bvalid(bvalid), .bready(bready),
	.araddr(araddr), .arvalid(arvalid), .arready(arready),
	.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
);
